// ==== core/ssr_bank.sv ====
// status reporting register bank: condition, event, enable, summary
`timescale 1ns/1ps
module ssr_bank (
    input  wire logic             clk_i,      // system clock
    input  wire logic             resetn_i,   // sync reset, low
    input  wire ssr_pkg::ssr_req_s req_i,     // register access
    input  wire ssr_pkg::ssr_src_s src_i,     // live status sources
    input  wire ssr_pkg::ssr_std_s std_i,     // standard event strobes
    input  wire logic             preset_i,   // status preset pulse
    input  wire logic             resp_wait_i,// response waiting
    input  wire logic             queue_ne_i, // error queue not empty
    output logic [15:0]           rdata_o,    // read data, registered
    output logic                  srq_o       // service request
);

    // -------------------------------------------------------------
    // live state
    // -------------------------------------------------------------
    logic [15:0] op_live;
    logic [15:0] wn_live;

    always_comb begin
        op_live = 16'h0000;
        op_live[ssr_pkg::OP_CAL]  = src_i.calibrating;
        op_live[ssr_pkg::OP_MEAS] = src_i.measuring;
        op_live[ssr_pkg::OP_TEST] = src_i.self_test;
        op_live[ssr_pkg::OP_SETA] = src_i.settling_a;
        op_live[ssr_pkg::OP_SETB] = src_i.settling_b;
        op_live[ssr_pkg::OP_PROG] = src_i.program_run;
        wn_live = 16'h0000;
        wn_live[ssr_pkg::WN_TIME] = src_i.clock_unset;
        wn_live[ssr_pkg::WN_TEMP] = src_i.oven_out;
        wn_live[ssr_pkg::WN_CAL]  = src_i.uncalibrated;
        wn_live[ssr_pkg::WN_PRES] = src_i.pres_over;
        wn_live[ssr_pkg::WN_PARAM] = src_i.param_ignored;
    end

    // -------------------------------------------------------------
    // access decode
    // -------------------------------------------------------------
    logic rd_op;        // read of operation latch
    logic rd_wn;        // read of warning latch
    logic rd_std;       // read of standard latch
    logic wr_op_mask;   // write of operation mask
    logic wr_wn_mask;   // write of warning mask
    logic wr_std_mask;  // write of standard mask
    logic wr_srq_mask;  // write of request mask

    // one decode shared by every read-clear and mask write
    function automatic logic hit(
        input logic       strobe,
        input logic [3:0] sel,
        input logic [3:0] want
    );
        hit = strobe && (sel == want);
    endfunction : hit

    always_comb begin
        rd_op       = hit(req_i.rd, req_i.sel, ssr_pkg::SEL_OP_LAT);
        rd_wn       = hit(req_i.rd, req_i.sel, ssr_pkg::SEL_WN_LAT);
        rd_std      = hit(req_i.rd, req_i.sel, ssr_pkg::SEL_STD_LAT);
        wr_op_mask  = hit(req_i.wr, req_i.sel, ssr_pkg::SEL_OP_MASK);
        wr_wn_mask  = hit(req_i.wr, req_i.sel, ssr_pkg::SEL_WN_MASK);
        wr_std_mask = hit(req_i.wr, req_i.sel, ssr_pkg::SEL_STD_MASK);
        wr_srq_mask = hit(req_i.wr, req_i.sel, ssr_pkg::SEL_SRQ_MASK);
    end

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // set wins over read clear, so an edge seen in the read cycle
    // is kept for the next read instead of being lost
    function automatic logic [15:0] latch_next(
        input logic [15:0] cur,
        input logic [15:0] set,
        input logic        clr
    );
        latch_next = (clr ? 16'h0000 : cur) | set;
    endfunction : latch_next

    // any latched bit whose enable is one
    function automatic logic any_enabled(
        input logic [15:0] lat,
        input logic [15:0] mask
    );
        any_enabled = |(lat & mask);
    endfunction : any_enabled

    // 8-bit registers read back with a zero upper byte
    function automatic logic [15:0] widen(
        input logic [7:0] v
    );
        widen = {8'h00, v};
    endfunction : widen

    // -------------------------------------------------------------
    // operation group: history and event latch
    // -------------------------------------------------------------
    logic [15:0] op_prev_q;  // live state one cycle ago
    logic [15:0] op_prev_d;
    logic [15:0] op_lat_q;   // latched events
    logic [15:0] op_lat_d;

    always_comb begin
        op_prev_d = op_live;
        // any edge of a condition bit latches
        op_lat_d  = latch_next(op_lat_q, op_live ^ op_prev_q, rd_op);
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            // history starts low: a source high at release latches
            op_prev_q <= 16'h0000;
            op_lat_q  <= 16'h0000;
        end else begin
            op_prev_q <= op_prev_d;
            op_lat_q  <= op_lat_d;
        end
    end

    // -------------------------------------------------------------
    // warning group: history and event latch
    // -------------------------------------------------------------
    logic [15:0] wn_prev_q;  // live state one cycle ago
    logic [15:0] wn_prev_d;
    logic [15:0] wn_lat_q;   // latched events
    logic [15:0] wn_lat_d;

    always_comb begin
        wn_prev_d = wn_live;
        // any edge of a condition bit latches
        wn_lat_d  = latch_next(wn_lat_q, wn_live ^ wn_prev_q, rd_wn);
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wn_prev_q <= 16'h0000;
            wn_lat_q  <= 16'h0000;
        end else begin
            wn_prev_q <= wn_prev_d;
            wn_lat_q  <= wn_lat_d;
        end
    end

    // -------------------------------------------------------------
    // standard event latch
    // -------------------------------------------------------------
    logic [7:0] std_lat_q;  // latched standard events
    logic [7:0] std_lat_d;

    always_comb begin
        std_lat_d = rd_std ? 8'h00 : std_lat_q;
        std_lat_d[ssr_pkg::SE_CMD] = std_lat_d[ssr_pkg::SE_CMD]
                                     | std_i.cmd_err;
        std_lat_d[ssr_pkg::SE_EXE] = std_lat_d[ssr_pkg::SE_EXE]
                                     | std_i.exe_err;
        std_lat_d[ssr_pkg::SE_DEV] = std_lat_d[ssr_pkg::SE_DEV]
                                     | std_i.dev_err;
        std_lat_d[ssr_pkg::SE_QRY] = std_lat_d[ssr_pkg::SE_QRY]
                                     | std_i.qry_err;
        std_lat_d[ssr_pkg::SE_OPC] = std_lat_d[ssr_pkg::SE_OPC]
                                     | std_i.op_done;
        std_lat_d[ssr_pkg::SE_RSV6] = 1'b0;
        std_lat_d[ssr_pkg::SE_RSV1] = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            std_lat_q <= ssr_pkg::RST_STD;
        end else begin
            std_lat_q <= std_lat_d;
        end
    end

    // -------------------------------------------------------------
    // group enable masks
    // -------------------------------------------------------------
    logic [15:0] op_mask_q;  // operation enables
    logic [15:0] op_mask_d;
    logic [15:0] wn_mask_q;  // warning enables
    logic [15:0] wn_mask_d;

    always_comb begin
        op_mask_d = op_mask_q;
        wn_mask_d = wn_mask_q;
        if (wr_op_mask) begin
            op_mask_d = req_i.wdata;
        end
        if (wr_wn_mask) begin
            wn_mask_d = req_i.wdata;
        end
        // preset wins over a same-cycle write
        if (preset_i) begin
            op_mask_d = ssr_pkg::RST_MASK16;
            wn_mask_d = ssr_pkg::RST_MASK16;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            op_mask_q <= ssr_pkg::RST_MASK16;
            wn_mask_q <= ssr_pkg::RST_MASK16;
        end else begin
            op_mask_q <= op_mask_d;
            wn_mask_q <= wn_mask_d;
        end
    end

    // -------------------------------------------------------------
    // standard and request enable masks
    // -------------------------------------------------------------
    logic [7:0] std_mask_q;  // standard event enables
    logic [7:0] std_mask_d;
    logic [7:0] srq_mask_q;  // service request enables
    logic [7:0] srq_mask_d;

    always_comb begin
        std_mask_d = std_mask_q;
        srq_mask_d = srq_mask_q;
        // preset leaves these two alone: only group masks clear
        if (wr_std_mask) begin
            std_mask_d = req_i.wdata[7:0];
        end
        if (wr_srq_mask) begin
            srq_mask_d = req_i.wdata[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            std_mask_q <= ssr_pkg::RST_MASK8;
            srq_mask_q <= ssr_pkg::RST_MASK8;
        end else begin
            std_mask_q <= std_mask_d;
            srq_mask_q <= srq_mask_d;
        end
    end

    // -------------------------------------------------------------
    // summary byte and service request
    // -------------------------------------------------------------
    logic [7:0] summary;     // status byte as read
    logic [7:0] srq_enable;  // request mask without bit 6

    always_comb begin
        summary = 8'h00;
        summary[ssr_pkg::SB_OPERATION_GROUP] = any_enabled(op_lat_q, op_mask_q);
        summary[ssr_pkg::SB_WARN] = any_enabled(wn_lat_q, wn_mask_q);
        summary[ssr_pkg::SB_STDSUM] = any_enabled(widen(std_lat_q),
                                                  widen(std_mask_q));
        summary[ssr_pkg::SB_RESP] = resp_wait_i;
        // queue not empty; bits 1,0 zero
        summary[ssr_pkg::SB_QUEUE] = queue_ne_i;
        // mask bit 6 has no effect
        srq_enable = srq_mask_q;
        srq_enable[ssr_pkg::SB_SRQ] = 1'b0;
        // combinational, no loop through bit 6
        srq_o = |(summary & srq_enable);
        summary[ssr_pkg::SB_SRQ] = srq_o;
    end

    // -------------------------------------------------------------
    // read data
    // -------------------------------------------------------------
    logic [15:0] rdata_q;  // held until the next read
    logic [15:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (req_i.rd) begin
            case (req_i.sel)
                ssr_pkg::SEL_SUMMARY:  rdata_d = widen(summary);
                ssr_pkg::SEL_SRQ_MASK: rdata_d = widen(srq_mask_q);
                ssr_pkg::SEL_STD_LAT:  rdata_d = widen(std_lat_q);
                ssr_pkg::SEL_STD_MASK: rdata_d = widen(std_mask_q);
                ssr_pkg::SEL_OP_LAT:   rdata_d = op_lat_q;
                ssr_pkg::SEL_OP_LIVE:  rdata_d = op_live;
                ssr_pkg::SEL_OP_MASK:  rdata_d = op_mask_q;
                ssr_pkg::SEL_WN_LAT:   rdata_d = wn_lat_q;
                ssr_pkg::SEL_WN_LIVE:  rdata_d = wn_live;
                ssr_pkg::SEL_WN_MASK:  rdata_d = wn_mask_q;
                // unmapped selects read zero
                default:               rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

endmodule : ssr_bank

// ==== common/ssr_pkg.sv ====
// constants and carriers for the status reporting register bank
// Notes on behaviour
// - live state registers show sources unlatched
// - event latch sets on any condition change
// - reading event latch returns then clears
// - enabled latched events set summary bits
// - service request when enabled status bit set
// - bit 7 operation, bit 3 warning summary
// - bit 6 request pending, mask bit ignored
// - bit 5 enabled standard event summary
// - bit 4 response waiting in buffer
// - bit 2 queue not empty, bits 1,0 zero
// - standard bit 7 power-up, bit 6 zero
// - bits 5,4,3 syntax, execution, device faults
// - bit 2 query with empty output queue
// - bit 0 operation complete, bit 1 zero
// - operation bits 0,4,8 calibrate, measure, test
// - operation bits 1,2 channel settling
// - operation bit 14 program running
// - warning bits 2,3 clock unset, oven range
// - warning bits 7,8 uncalibrated, overrange
// - warning bit 14 ignored parameter
// - preset clears operation and warning masks
package ssr_pkg;

    // -------------------------------------------------------------
    // register selects
    // -------------------------------------------------------------
    localparam logic [3:0] SEL_SUMMARY  = 4'h0;
    localparam logic [3:0] SEL_SRQ_MASK = 4'h1;
    localparam logic [3:0] SEL_STD_LAT  = 4'h2;
    localparam logic [3:0] SEL_STD_MASK = 4'h3;
    localparam logic [3:0] SEL_OP_LAT   = 4'h4;
    localparam logic [3:0] SEL_OP_LIVE  = 4'h5;
    localparam logic [3:0] SEL_OP_MASK  = 4'h6;
    localparam logic [3:0] SEL_WN_LAT   = 4'h7;
    localparam logic [3:0] SEL_WN_LIVE  = 4'h8;
    localparam logic [3:0] SEL_WN_MASK  = 4'h9;

    // -------------------------------------------------------------
    // bit positions
    // -------------------------------------------------------------
    localparam int SB_OPERATION_GROUP   = 7;
    localparam int SB_SRQ    = 6;
    localparam int SB_STDSUM = 5;
    localparam int SB_RESP   = 4;
    localparam int SB_WARN   = 3;
    localparam int SB_QUEUE  = 2;

    localparam int SE_PWR    = 7;
    localparam int SE_CMD    = 5;
    localparam int SE_EXE    = 4;
    localparam int SE_DEV    = 3;
    localparam int SE_QRY    = 2;
    localparam int SE_OPC    = 0;
    localparam int SE_RSV6   = 6;
    localparam int SE_RSV1   = 1;

    localparam int OP_CAL    = 0;
    localparam int OP_SETA   = 1;
    localparam int OP_SETB   = 2;
    localparam int OP_MEAS   = 4;
    localparam int OP_TEST   = 8;
    localparam int OP_PROG   = 14;

    localparam int WN_TIME   = 2;
    localparam int WN_TEMP   = 3;
    localparam int WN_CAL    = 7;
    localparam int WN_PRES   = 8;
    localparam int WN_PARAM  = 14;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0]  RST_MASK8  = 8'h00;
    localparam logic [15:0] RST_MASK16 = 16'h0000;
    localparam logic [7:0]  RST_STD    = 8'h80;

    // status sources from the instrument
    typedef struct packed {
        logic calibrating;
        logic settling_a;
        logic settling_b;
        logic measuring;
        logic self_test;
        logic program_run;
        logic clock_unset;
        logic oven_out;
        logic uncalibrated;
        logic pres_over;
        logic param_ignored;
    } ssr_src_s;

    // one-cycle standard event strobes
    typedef struct packed {
        logic cmd_err;
        logic exe_err;
        logic dev_err;
        logic qry_err;
        logic op_done;
    } ssr_std_s;

    // register access request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] sel;
        logic [15:0] wdata;
    } ssr_req_s;

endpackage : ssr_pkg

// ==== testbench/ssr_bank_props.sv ====
// port checker for the status reporting bank
`timescale 1ns/1ps
module ssr_bank_props (
    input wire logic              clk_i,       // clock
    input wire logic              resetn_i,    // reset, low
    input wire ssr_pkg::ssr_req_s req_i,       // access
    input wire ssr_pkg::ssr_src_s src_i,       // sources
    input wire ssr_pkg::ssr_std_s std_i,       // strobes
    input wire logic              preset_i,    // preset
    input wire logic              resp_wait_i, // response
    input wire logic              queue_ne_i,  // queue
    input wire logic [15:0]       rdata_o,     // read data
    input wire logic              srq_o        // request
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic [15:0] op_v;
    logic [15:0] wn_v;
    logic [3:0]  s;
    logic        r;
    assign s = req_i.sel;
    assign r = req_i.rd;
    assign op_v = {1'b0, src_i.program_run, 5'h00, src_i.self_test, 3'h0,
        src_i.measuring, 1'b0, src_i.settling_b, src_i.settling_a,
        src_i.calibrating};
    assign wn_v = {1'b0, src_i.param_ignored, 5'h00, src_i.pres_over,
        src_i.uncalibrated, 3'h0, src_i.oven_out, src_i.clock_unset, 2'h0};

    AST_OP_LIVE: assert property (
        r && s == ssr_pkg::SEL_OP_LIVE |=> rdata_o == $past(op_v))
        else $error("operation live state mismatch");
    AST_WN_LIVE: assert property (
        r && s == ssr_pkg::SEL_WN_LIVE |=> rdata_o == $past(wn_v))
        else $error("warning live state mismatch");
    AST_SUM_RSV: assert property (
        r && s == ssr_pkg::SEL_SUMMARY |=> (rdata_o & 16'hFF03) == 16'h0000)
        else $error("summary reserved bits set");
    AST_SUM_LVL: assert property (
        r && s == ssr_pkg::SEL_SUMMARY |=> rdata_o[4] == $past(resp_wait_i)
        && rdata_o[2] == $past(queue_ne_i))
        else $error("summary response or queue bit wrong");
    AST_SUM_SRQ: assert property (
        r && s == ssr_pkg::SEL_SUMMARY |=> rdata_o[6] == $past(srq_o))
        else $error("summary request bit differs from srq_o");
    AST_STD_RSV: assert property (
        r && s == ssr_pkg::SEL_STD_LAT |=> (rdata_o & 16'hFF42) == 16'h0000)
        else $error("standard latch reserved bits set");
    AST_RD_CLR: assert property (
        (r && s == ssr_pkg::SEL_OP_LAT && $stable(src_i) && $past(resetn_i))
        ##1 $stable(src_i) ##1 (r && s == ssr_pkg::SEL_OP_LAT)
        |=> rdata_o == 16'h0000)
        else $error("event latch not cleared by read");
    AST_EV_SET: assert property (
        ($changed(src_i.measuring) && $past(resetn_i))
        ##1 (r && s == ssr_pkg::SEL_OP_LAT) |=> rdata_o[4])
        else $error("condition change not latched");
    AST_PRESET: assert property (
        preset_i ##1 !req_i.wr ##1 (r && !req_i.wr
        && (s == ssr_pkg::SEL_OP_MASK || s == ssr_pkg::SEL_WN_MASK))
        |=> rdata_o == 16'h0000)
        else $error("mask survived preset");
endmodule : ssr_bank_props

bind ssr_bank ssr_bank_props i_props (.clk_i(clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .src_i(src_i), .std_i(std_i), .preset_i(preset_i),
    .resp_wait_i(resp_wait_i), .queue_ne_i(queue_ne_i),
    .rdata_o(rdata_o), .srq_o(srq_o));

// ==== testbench/ssr_host.sv ====
// host controller model issuing register reads and writes
`timescale 1ns/1ps
module ssr_host (
    input  wire logic [15:0] rdata_i, // read data
    input  wire logic        clk_i,   // clock
    output ssr_pkg::ssr_req_s req_o   // access
);
    initial req_o = '0;
    task automatic put(input logic w, input logic [3:0] sel,
        input logic [15:0] d, output logic [15:0] q);
        @(negedge clk_i);
        req_o = '{rd: !w, wr: w, sel: sel, wdata: d};
        @(negedge clk_i);
        q = rdata_i;
        req_o.rd = 1'b0;
        req_o.wr = 1'b0;
        // released data never keeps its last value
        req_o.wdata = ~d;
    endtask : put
endmodule : ssr_host

// ==== testbench/test_ssr_bank.sv ====
// self-checking bench for the status reporting register bank
`timescale 1ns/1ps
module test_ssr_bank;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    err_count++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic preset = 1'b0;
    logic resp = 1'b0;
    logic qne = 1'b0;
    logic srq;
    logic [15:0] rdata;
    logic [15:0] q;
    ssr_pkg::ssr_req_s req;
    ssr_pkg::ssr_src_s src = '0;
    ssr_pkg::ssr_std_s stb = '0;
    logic [15:0] exp_std [5] = '{16'h0020, 16'h0010, 16'h0008,
        16'h0004, 16'h0001};
    int err_count = 0;
    int comparisons = 0;

    always #10 clk_i = ~clk_i;
    ssr_bank i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
        .src_i(src), .std_i(stb), .preset_i(preset), .resp_wait_i(resp),
        .queue_ne_i(qne), .rdata_o(rdata), .srq_o(srq));
    ssr_host i_host (.rdata_i(rdata), .clk_i(clk_i), .req_o(req));

    task automatic rd(input logic [3:0] s, input logic [15:0] e);
        i_host.put(1'b0, s, 16'h0000, q);
        `CHK(q, e)
    endtask : rd
    task automatic wr(input logic [3:0] s, input logic [15:0] d);
        i_host.put(1'b1, s, d, q);
    endtask : wr
    task automatic results;
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    initial begin
        repeat (6) @(negedge clk_i);
        resetn_i = 1'b1;
        rd(ssr_pkg::SEL_STD_LAT, 16'h0080);
        rd(ssr_pkg::SEL_STD_LAT, 16'h0000);
        src = '1;
        rd(ssr_pkg::SEL_OP_LIVE, 16'h4117);
        rd(ssr_pkg::SEL_WN_LIVE, 16'h418C);
        rd(ssr_pkg::SEL_OP_LAT, 16'h4117);
        rd(ssr_pkg::SEL_OP_LAT, 16'h0000);
        src = '0;
        rd(ssr_pkg::SEL_OP_LAT, 16'h4117);
        wr(ssr_pkg::SEL_OP_MASK, 16'h0010);
        wr(ssr_pkg::SEL_SRQ_MASK, 16'h0080);
        src.measuring = 1'b1;
        @(negedge clk_i);
        `CHK(srq, 1'b1)
        rd(ssr_pkg::SEL_SUMMARY, 16'h00C0);
        rd(ssr_pkg::SEL_OP_LAT, 16'h0010);
        `CHK(srq, 1'b0)
        wr(ssr_pkg::SEL_WN_MASK, 16'h0004);
        rd(ssr_pkg::SEL_SUMMARY, 16'h0008);
        wr(ssr_pkg::SEL_SRQ_MASK, 16'h0048);
        `CHK(srq, 1'b1)
        wr(ssr_pkg::SEL_SRQ_MASK, 16'h0040);
        `CHK(srq, 1'b0)
        @(negedge clk_i);
        preset = 1'b1;
        @(negedge clk_i);
        preset = 1'b0;
        rd(ssr_pkg::SEL_WN_MASK, 16'h0000);
        rd(ssr_pkg::SEL_OP_MASK, 16'h0000);
        rd(ssr_pkg::SEL_SUMMARY, 16'h0000);
        // one strobe at a time so each flag shows alone
        for (int i = 0; i < 5; i++) begin
            @(negedge clk_i);
            stb = 5'h10 >> i;
            @(negedge clk_i);
            stb = '0;
            rd(ssr_pkg::SEL_STD_LAT, exp_std[i]);
        end
        wr(ssr_pkg::SEL_STD_MASK, 16'h0001);
        stb.op_done = 1'b1;
        resp = 1'b1;
        qne = 1'b1;
        @(negedge clk_i);
        stb = '0;
        rd(ssr_pkg::SEL_SUMMARY, 16'h0034);
        wr(ssr_pkg::SEL_SRQ_MASK, 16'h0004);
        `CHK(srq, 1'b1)
        rd(4'hF, 16'h0000);
        results();
    end
endmodule : test_ssr_bank
